// [rtl/bre_pkg.sv]
// shared constants and types for the bit-reverse and program-space address block
package bre_pkg;

  // register port widths
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 16;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_BITREV = 4'h0;
  localparam logic [3:0] OFS_TABLE_PAGE = 4'h1;
  localparam logic [3:0] OFS_VISPAG = 4'h2;
  localparam logic [3:0] OFS_MODE   = 4'h3;
  localparam logic [3:0] OFS_CORE   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // field positions
  localparam int unsigned BITREV_ENABLE_BIT    = 15; // bitrev_enable in bitrev_control_reg
  localparam int unsigned XB_MSB      = 14; // bitrev_modifier is bits 14..0
  localparam int unsigned XMOD_BIT    = 15; // x circular enable in address_mode_control_reg
  localparam int unsigned BWM_LSB     = 8;  // bitrev_pointer_select, 4 bits
  localparam int unsigned XWM_LSB     = 0;  // x circular pointer select, 4 bits
  localparam int unsigned PSV_BIT     = 2;  // visibility_enable in core_control_reg
  localparam int unsigned TBL_CFG_BIT = 7;  // table page selects configuration space
  localparam int unsigned EA_WIN_BIT  = 15; // ea bit that opens the visibility window

  // pointer select value meaning "no pointer"
  localparam logic [3:0] NO_POINTER = 4'hF;

  // reset values
  localparam logic [15:0] RST_BITREV = 16'h0000;
  localparam logic [15:0] RST_MODE   = 16'h0F0F;
  localparam logic [15:0] RST_CORE   = 16'h0000;
  localparam logic [7:0]  RST_PAGE   = 8'h00;
  localparam logic [23:0] RST_PC     = 24'h00_0000;

  // program counter step per 24-bit program word
  localparam logic [23:0] PC_STEP = 24'h00_0002;

  // indirect addressing modes presented by the pipeline
  typedef enum logic [2:0] {
    AM_DIRECT   = 3'h0,
    AM_IND      = 3'h1,
    AM_POST_DEC = 3'h2,
    AM_POST_INC = 3'h3,
    AM_PRE_DEC  = 3'h4,
    AM_PRE_INC  = 3'h5,
    AM_REG_OFS  = 3'h6,
    AM_LIT_OFS  = 3'h7
  } bre_amode_t;

  // program-space access sequencer states
  typedef enum logic [1:0] {
    PS_IDLE  = 2'h0,
    PS_FETCH = 2'h1,
    PS_EXTRA = 2'h2,
    PS_DONE  = 2'h3
  } bre_pstate_t;

endpackage

// [rtl/bre_revadd.sv]
// reversed-carry adder for bit-reversed pointer updates
`timescale 1ns/1ps
module bre_revadd #(
  parameter int unsigned WIDTH = 15
) (
  // operands, word-index aligned
  input  wire logic [WIDTH-1:0] base,
  input  wire logic [WIDTH-1:0] modifier,
  // reversed-carry sum
  output logic      [WIDTH-1:0] sum
);

  // refuse widths the word-index path cannot hold
  if (WIDTH < 1 || WIDTH > 15) begin : g_bad_width
    $error("bre_revadd WIDTH must be 1 to 15");
  end

  logic [WIDTH-1:0] rev_base; // base, mirrored
  logic [WIDTH-1:0] rev_mod;  // modifier, mirrored
  logic [WIDTH-1:0] rev_sum;  // plain sum of mirrored operands

  // mirror operands and result per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_mirror
    assign rev_base[i] = base[WIDTH-1-i];
    assign rev_mod[i]  = modifier[WIDTH-1-i];
    assign sum[i]      = rev_sum[WIDTH-1-i];
  end

  // carries run msb toward lsb; carry out of bit 0 drops, so it wraps in the buffer
  assign rev_sum = rev_base + rev_mod;

endmodule

// [rtl/bre_top.sv]
// effective-address generator: bit-reversed writes, table reads, visibility window
// Overview of operation
// - bitrev needs pointer select not 15, enable, increment
// - only word writes, pre/post increment; else normal
// - pointer plus modifier; mode offset ignored
// - bitrev address lsb forced zero, modifier scaled
// - modifier is a 15-bit pivot field
// - bitrev beats circular on write generator only
// - table address is page above 16-bit ea
// - table page bit 7 selects configuration space
// - visibility address is page above ea 14..0
// - redirect only when ea bit 15 and enable
// - visibility reads return low 16 bits, read-only
// - visibility read stretches instruction one cycle
// - low table read: word or selected byte
// - high word read: bits 23..16, upper zero
// - high byte read: phantom byte reads zero
// - program counter steps two per program word
// - modifier added in reversed bit order
// - bitrev only in x write generator
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module bre_top (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // register port
  input  wire logic [bre_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [bre_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [bre_pkg::REG_DW-1:0] reg_rdata,
  // x address generator request
  input  wire logic                    agu_req,
  input  wire logic                    agu_write,
  input  wire logic                    agu_byte,
  input  wire bre_pkg::bre_amode_t     agu_mode,
  input  wire logic [3:0]              agu_reg,
  input  wire logic [15:0]             agu_ptr,
  input  wire logic [15:0]             agu_offset,
  // x address generator answer
  output logic                         ea_valid,
  output logic      [15:0]             ea_addr,
  output logic                         ptr_wb_en,
  output logic      [15:0]             ptr_wb_value,
  output logic                         ea_bitrev,
  output logic                         ea_modulo,
  // table read request
  input  wire logic                    tbl_req,
  input  wire logic                    tbl_high,
  input  wire logic                    tbl_byte,
  input  wire logic [15:0]             tbl_ea,
  // data read request for the visibility window
  input  wire logic                    dread_req,
  input  wire logic [15:0]             dread_ea,
  // program memory port
  output logic                         prog_rd,
  output logic      [23:0]             prog_addr,
  output logic                         prog_cfg,
  input  wire logic [23:0]             prog_rdata,
  // program-space read answer
  output logic                         psv_hit,
  output logic                         prog_data_valid,
  output logic      [15:0]             prog_data,
  output logic                         core_stall,
  // program counter
  input  wire logic                    pc_load,
  input  wire logic [23:0]             pc_load_value,
  input  wire logic                    pc_advance,
  output logic      [23:0]             pc
);
  import bre_pkg::*;
  // software-visible registers
  logic [15:0] bitrev_control;  // enable plus modifier
  logic [7:0]  table_page;      // upper table address byte
  logic [7:0]  visibility_page; // upper visibility address byte
  logic [15:0] mode_control;    // circular and bitrev pointer selects
  logic [15:0] core_control;    // visibility enable
  logic [15:0] next_bitrev_control, next_mode_control, next_core_control, next_reg_rdata;
  logic [7:0]  next_table_page, next_visibility_page;
  // sequencer state, used by status read
  bre_pstate_t state;
  logic        last_bitrev; // last ea was bit-reversed
  logic        last_psv;    // last program access was a window read
  // decoded configuration: enable, pivot, designated and circular pointers
  wire logic        bitrev_enable         = bitrev_control[BITREV_ENABLE_BIT];
  wire logic [14:0] bitrev_modifier       = bitrev_control[XB_MSB:0];
  wire logic [3:0]  bitrev_pointer_select = mode_control[BWM_LSB +: 4];
  wire logic [3:0]  xmod_select           = mode_control[XWM_LSB +: 4];
  wire logic        xmod_enable           = mode_control[XMOD_BIT];
  wire logic        visibility_enable     = core_control[PSV_BIT];
  // bitrev armed on some pointer; pointer 15 is the stack and never reverses
  wire logic        bitrev_cfg = bitrev_enable && (bitrev_pointer_select != NO_POINTER);
  // register writes and read mux; unmapped reads return zero
  always_comb begin
    next_bitrev_control  = bitrev_control;
    next_table_page      = table_page;
    next_visibility_page = visibility_page;
    next_mode_control    = mode_control;
    next_core_control    = core_control;
    next_reg_rdata       = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_BITREV: next_bitrev_control  = reg_wdata;
        OFS_TABLE_PAGE: next_table_page      = reg_wdata[7:0];
        OFS_VISPAG: next_visibility_page = reg_wdata[7:0];
        OFS_MODE:   next_mode_control    = reg_wdata;
        OFS_CORE:   next_core_control    = {13'h0000, reg_wdata[PSV_BIT], 2'h0};
        default:    ; // read-only or unmapped: write dropped
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_BITREV: next_reg_rdata = bitrev_control;
        OFS_TABLE_PAGE: next_reg_rdata = {8'h00, table_page};
        OFS_VISPAG: next_reg_rdata = {8'h00, visibility_page};
        OFS_MODE:   next_reg_rdata = mode_control;
        OFS_CORE:   next_reg_rdata = core_control;
        OFS_STATUS: next_reg_rdata = {11'h000, table_page[TBL_CFG_BIT], bitrev_cfg,
                                      last_psv, last_bitrev, (state != PS_IDLE)};
        default:    next_reg_rdata = 16'h0000;
      endcase
    end
  end
  // register file flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitrev_control  <= RST_BITREV;
      table_page      <= RST_PAGE;
      visibility_page <= RST_PAGE;
      mode_control    <= RST_MODE;
      core_control    <= RST_CORE;
      reg_rdata       <= 16'h0000;
    end else begin
      bitrev_control  <= next_bitrev_control;
      table_page      <= next_table_page;
      visibility_page <= next_visibility_page;
      mode_control    <= next_mode_control;
      core_control    <= next_core_control;
      reg_rdata       <= next_reg_rdata;
    end
  end
  // address generator
  logic [14:0] rev_sum; // reversed-carry word index
  logic        next_ea_valid, next_ptr_wb_en, next_ea_bitrev, next_ea_modulo, next_last_bitrev;
  logic [15:0] next_ea_addr, next_ptr_wb_value;
  wire logic        incr_mode = (agu_mode == AM_PRE_INC) || (agu_mode == AM_POST_INC);
  wire logic [15:0] plain_sum = agu_ptr + agu_offset; // pointer plus mode offset
  // bit-reversed only for the designated pointer, word writes, increment modes
  wire logic        br_hit = bitrev_cfg && (agu_reg == bitrev_pointer_select)
                             && agu_write && !agu_byte && incr_mode;
  // write generator loses circular mode while bitrev is armed; reads keep it
  wire logic        mod_hit = xmod_enable && (xmod_select != NO_POINTER)
                              && (agu_reg == xmod_select) && !(agu_write && bitrev_cfg);
  // modifier aligned to word index: scaled to a byte step
  bre_revadd #(.WIDTH(15)) u_revadd (
    .base     (agu_ptr[15:1]),
    .modifier (bitrev_modifier),
    .sum      (rev_sum)
  );
  // next ea, write-back and flags
  always_comb begin
    next_ea_valid     = agu_req;
    next_ea_addr      = ea_addr;
    next_ptr_wb_en    = 1'b0;
    next_ptr_wb_value = ptr_wb_value;
    next_ea_bitrev    = 1'b0;
    next_ea_modulo    = 1'b0;
    next_last_bitrev  = last_bitrev;
    if (agu_req) begin
      next_ea_bitrev   = br_hit;
      next_ea_modulo   = mod_hit;
      next_last_bitrev = br_hit;
      if (br_hit) begin
        // mode offset ignored, lsb always clear
        next_ptr_wb_en    = 1'b1;
        next_ptr_wb_value = {rev_sum, 1'b0};
        next_ea_addr = (agu_mode == AM_PRE_INC) ? {rev_sum, 1'b0} : {agu_ptr[15:1], 1'b0};
      end else begin
        case (agu_mode)
          AM_PRE_INC, AM_PRE_DEC: begin
            next_ea_addr      = plain_sum;
            next_ptr_wb_en    = 1'b1;
            next_ptr_wb_value = plain_sum;
          end
          AM_POST_INC, AM_POST_DEC: begin
            next_ea_addr      = agu_ptr;
            next_ptr_wb_en    = 1'b1;
            next_ptr_wb_value = plain_sum;
          end
          AM_REG_OFS, AM_LIT_OFS: next_ea_addr = plain_sum; // pointer unchanged
          default:                next_ea_addr = agu_ptr;   // direct, plain indirect
        endcase
      end
    end
  end
  // address generator flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ea_valid     <= 1'b0;
      ea_addr      <= 16'h0000;
      ptr_wb_en    <= 1'b0;
      ptr_wb_value <= 16'h0000;
      ea_bitrev    <= 1'b0;
      ea_modulo    <= 1'b0;
      last_bitrev  <= 1'b0;
    end else begin
      ea_valid     <= next_ea_valid;
      ea_addr      <= next_ea_addr;
      ptr_wb_en    <= next_ptr_wb_en;
      ptr_wb_value <= next_ptr_wb_value;
      ea_bitrev    <= next_ea_bitrev;
      ea_modulo    <= next_ea_modulo;
      last_bitrev  <= next_last_bitrev;
    end
  end
  // program-space access sequencer
  bre_pstate_t next_state;
  // captured request: high read, byte mode, byte select (ea bit 0), window read
  logic        op_high, op_byte, op_bsel, op_psv;
  logic        next_op_high, next_op_byte, next_op_bsel, next_op_psv;
  logic        next_prog_rd, next_prog_cfg, next_psv_hit, next_prog_data_valid;
  logic        next_core_stall, next_last_psv;
  logic [23:0] next_prog_addr;
  logic [15:0] next_prog_data;
  // table wins a tie; requests seen while busy are dropped
  always_comb begin
    next_state           = state;
    next_op_high         = op_high;
    next_op_byte         = op_byte;
    next_op_bsel         = op_bsel;
    next_op_psv          = op_psv;
    next_prog_rd         = 1'b0;
    next_prog_addr       = prog_addr;
    next_prog_cfg        = prog_cfg;
    next_psv_hit         = 1'b0;
    next_prog_data_valid = 1'b0;
    next_prog_data       = prog_data;
    next_core_stall      = core_stall;
    next_last_psv        = last_psv;
    case (state)
      PS_IDLE: begin
        if (tbl_req) begin
          next_prog_addr  = {table_page, tbl_ea};
          next_prog_cfg   = table_page[TBL_CFG_BIT];
          next_prog_rd    = 1'b1;
          next_op_high    = tbl_high;
          next_op_byte    = tbl_byte;
          next_op_bsel    = tbl_ea[0];
          next_op_psv     = 1'b0;
          next_last_psv   = 1'b0;
          next_core_stall = 1'b1;
          next_state      = PS_FETCH;
        end else if (dread_req && dread_ea[EA_WIN_BIT] && visibility_enable) begin
          // user space only: bit 23 held low
          next_prog_addr  = {1'b0, visibility_page, dread_ea[14:0]};
          next_prog_cfg   = 1'b0;
          next_prog_rd    = 1'b1;
          next_op_psv     = 1'b1;
          next_last_psv   = 1'b1;
          next_psv_hit    = 1'b1;
          next_core_stall = 1'b1;
          next_state      = PS_FETCH;
        end
      end
      PS_FETCH: begin
        // a window read issues a second fetch, which costs the extra cycle
        next_prog_rd = op_psv;
        next_state   = op_psv ? PS_EXTRA : PS_DONE;
      end
      PS_EXTRA: next_state = PS_DONE;
      PS_DONE: begin
        next_prog_data_valid = 1'b1;
        next_core_stall      = 1'b0;
        next_state           = PS_IDLE;
        if (op_psv || (!op_high && !op_byte)) begin
          next_prog_data = prog_rdata[15:0];
        end else if (!op_high) begin
          next_prog_data = {8'h00, op_bsel ? prog_rdata[15:8] : prog_rdata[7:0]};
        end else if (op_byte && op_bsel) begin
          next_prog_data = 16'h0000;
        end else begin
          next_prog_data = {8'h00, prog_rdata[23:16]};
        end
      end
      default: next_state = PS_IDLE;
    endcase
  end
  // sequencer flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= PS_IDLE;
      op_high         <= 1'b0;
      op_byte         <= 1'b0;
      op_bsel         <= 1'b0;
      op_psv          <= 1'b0;
      prog_rd         <= 1'b0;
      prog_addr       <= 24'h00_0000;
      prog_cfg        <= 1'b0;
      psv_hit         <= 1'b0;
      prog_data_valid <= 1'b0;
      prog_data       <= 16'h0000;
      core_stall      <= 1'b0;
      last_psv        <= 1'b0;
    end else begin
      state           <= next_state;
      op_high         <= next_op_high;
      op_byte         <= next_op_byte;
      op_bsel         <= next_op_bsel;
      op_psv          <= next_op_psv;
      prog_rd         <= next_prog_rd;
      prog_addr       <= next_prog_addr;
      prog_cfg        <= next_prog_cfg;
      psv_hit         <= next_psv_hit;
      prog_data_valid <= next_prog_data_valid;
      prog_data       <= next_prog_data;
      core_stall      <= next_core_stall;
      last_psv        <= next_last_psv;
    end
  end
  // program counter: load wins over advance, bit 0 kept clear
  logic [23:0] next_pc;
  always_comb begin
    next_pc = pc_load ? {pc_load_value[23:1], 1'b0} : (pc_advance ? pc + PC_STEP : pc);
  end
  // program counter flop
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= RST_PC;
    end else begin
      pc <= next_pc;
    end
  end
endmodule

// [verif/bre_pmem.sv]
// program memory model facing the address block
`timescale 1ns/1ps
module bre_pmem (
  // clock
  input  wire logic        core_clk,
  // read port
  input  wire logic        prog_rd,
  input  wire logic [23:0] prog_addr,
  output logic      [23:0] prog_rdata
);
  // arbitrary start so the idle pattern is never unknown
  initial prog_rdata = 24'h5a_5a5a;
  // one-cycle read; contents follow the low 16 address bits so every word within a page differs
  always_ff @(posedge core_clk) begin
    if (prog_rd) begin
      // words with address bit 15 set carry an all-ones top byte, so a stray fetch decodes as a no-op
      prog_rdata <= {prog_addr[15] ? 8'hff : prog_addr[7:0] ^ 8'h3c,
                     prog_addr[15:0] ^ 16'ha55a};
    end else begin
      // data hold has run out: toggle so a late sample is caught
      prog_rdata <= ~prog_rdata;
    end
  end
endmodule

// [verif/bre_top_assertions.sv]
// port-level checks of the address block
`timescale 1ns/1ps
module bre_chk (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                sys_rst,
  // address generator side
  input wire logic                agu_write,
  input wire logic                agu_byte,
  input wire bre_pkg::bre_amode_t agu_mode,
  input wire logic [3:0]          agu_reg,
  input wire logic                ea_valid,
  input wire logic [15:0]         ea_addr,
  input wire logic [15:0]         ptr_wb_value,
  input wire logic                ea_bitrev,
  input wire logic                ea_modulo,
  // program space side
  input wire logic [15:0]         tbl_ea,
  input wire logic                dread_req,
  input wire logic [15:0]         dread_ea,
  input wire logic                prog_rd,
  input wire logic [23:0]         prog_addr,
  input wire logic                prog_cfg,
  input wire logic                psv_hit,
  input wire logic                prog_data_valid,
  // program counter
  input wire logic                pc_load,
  input wire logic                pc_advance,
  input wire logic [23:0]         pc
);
  import bre_pkg::*;
  logic        bitrev_kind; // request shape that may reverse
  logic        win_req;     // read aimed at the upper half
  logic [14:0] win_lo;      // window offset bits
  assign bitrev_kind = agu_write && !agu_byte && (agu_mode inside {AM_POST_INC, AM_PRE_INC});
  assign win_req = dread_req && dread_ea[15];
  assign win_lo = dread_ea[14:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_bitrev_kind: assert property (ea_bitrev |-> $past(bitrev_kind))
    else $error("reversed address for wrong access kind");
  a_bitrev_ptr: assert property (ea_bitrev |-> $past(agu_reg) != NO_POINTER)
    else $error("reversed address through pointer 15");
  a_bitrev_align: assert property (ea_bitrev |-> !ea_addr[0] && !ptr_wb_value[0])
    else $error("reversed address not word aligned");
  a_bitrev_first: assert property (ea_bitrev |-> ea_valid && !ea_modulo)
    else $error("circular correction beside reversal");
  a_tbl_addr: assert property ($rose(prog_rd) && !psv_hit |-> prog_addr[15:0] == $past(tbl_ea))
    else $error("table address low half wrong");
  a_tbl_space: assert property ($rose(prog_rd) |-> prog_cfg == prog_addr[23])
    else $error("space select differs from page top bit");
  a_win_addr: assert property (psv_hit |-> !prog_addr[23] && prog_addr[14:0] == $past(win_lo))
    else $error("window address wrong");
  a_win_gate: assert property (psv_hit |-> $past(win_req))
    else $error("window hit without upper half read");
  a_win_stretch: assert property (psv_hit |-> prog_rd ##1 prog_rd ##1 !prog_rd ##1 prog_data_valid)
    else $error("window read not two fetches plus one");
  a_pc_step: assert property (pc_advance && !pc_load |=> pc == $past(pc) + 24'h00_0002)
    else $error("program counter step wrong");
  // main scenarios reached
  c_bitrev: cover property (ea_bitrev);
  c_window: cover property (psv_hit);
  c_prog: cover property (prog_data_valid);
endmodule
bind bre_top bre_chk bre_chk_i (.core_clk, .sys_rst, .agu_write, .agu_byte, .agu_mode, .agu_reg,
  .ea_valid, .ea_addr, .ptr_wb_value, .ea_bitrev, .ea_modulo, .tbl_ea, .dread_req, .dread_ea,
  .prog_rd, .prog_addr, .prog_cfg, .psv_hit, .prog_data_valid, .pc_load, .pc_advance, .pc);

// [verif/bre_top_test.sv]
// self-checking bench for the address block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module bre_top_test;
  import bre_pkg::*;
  logic core_clk, sys_rst, reg_wr, reg_rd, agu_req, agu_write, agu_byte;
  logic ea_valid, ptr_wb_en, ea_bitrev, ea_modulo, tbl_req, tbl_high, tbl_byte, dread_req;
  logic prog_rd, prog_cfg, psv_hit, prog_data_valid, core_stall, pc_load, pc_advance, brv;
  logic [3:0]  reg_addr, agu_reg;
  logic [7:0]  pg, vp;   // page values last written
  logic [15:0] reg_wdata, reg_rdata, agu_ptr, agu_offset, ea_addr, ptr_wb_value;
  logic [15:0] tbl_ea, dread_ea, prog_data, p, s, q;
  logic [23:0] prog_addr, prog_rdata, pc_load_value, pc;
  bre_amode_t  agu_mode;
  int          num_errors, compares, cycles;
  bre_top bre_top_i (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .agu_req, .agu_write, .agu_byte, .agu_mode, .agu_reg, .agu_ptr, .agu_offset, .ea_valid,
    .ea_addr, .ptr_wb_en, .ptr_wb_value, .ea_bitrev, .ea_modulo, .tbl_req, .tbl_high, .tbl_byte,
    .tbl_ea, .dread_req, .dread_ea, .prog_rd, .prog_addr, .prog_cfg, .prog_rdata, .psv_hit,
    .prog_data_valid, .prog_data, .core_stall, .pc_load, .pc_load_value, .pc_advance, .pc);
  bre_pmem bre_pmem_i (.core_clk, .prog_rd, .prog_addr, .prog_rdata);
  // 50 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // hang guard, far above the roughly 160 cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("Error %0t: timeout", $time);
      wrap_up();
    end
  end
  // same contents as the memory model
  function automatic logic [23:0] pm(input logic [23:0] a);
    return {a[15] ? 8'hff : a[7:0] ^ 8'h3c, a[15:0] ^ 16'ha55a};
  endfunction
  function automatic logic [14:0] rev15(input logic [14:0] v);
    for (int i = 0; i < 15; i++) rev15[i] = v[14-i];
  endfunction
  // carry runs from the top bit down: mirror, add, mirror back
  function automatic logic [14:0] revadd(input logic [14:0] a, input logic [14:0] b);
    return rev15(rev15(a) + rev15(b));
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk); reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // one address request; answer checked in the following cycle
  task automatic agu(input logic w, by, input bre_amode_t m, input logic [15:0] ptr,
                     input logic [15:0] e_ea, e_wb, input logic wb, br, mo);
    @(posedge core_clk); agu_req <= 1'b1; agu_write <= w; agu_byte <= by; agu_mode <= m;
    agu_ptr <= ptr; agu_offset <= 16'h0002;
    @(posedge core_clk); agu_req <= 1'b0;
    #1 `CHK({ea_valid, ea_addr, ptr_wb_en, ea_bitrev, ea_modulo}, {1'b1, e_ea, wb, br, mo})
    if (wb) `CHK(ptr_wb_value, e_wb)
  endtask
  // table read with the expected data worked out from the access kind
  task automatic tbl(input logic h, by, input logic [15:0] ea);
    logic [23:0] w;
    logic [15:0] d;
    w = pm({pg, ea});
    d = h ? ((by && ea[0]) ? 16'h0000 : {8'h00, w[23:16]})
          : (!by ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]});
    @(posedge core_clk); tbl_req <= 1'b1; tbl_high <= h; tbl_byte <= by; tbl_ea <= ea;
    @(posedge core_clk); tbl_req <= 1'b0;
    #1 `CHK({prog_rd, core_stall, prog_addr, prog_cfg}, {2'b11, pg, ea, pg[7]})
    repeat (2) @(posedge core_clk);
    #1 `CHK({prog_data_valid, core_stall, prog_data}, {2'b10, d})
  endtask
  task automatic win(input logic [15:0] ea, input logic hit);
    logic [23:0] a;
    a = {1'b0, vp, ea[14:0]};
    @(posedge core_clk); dread_req <= 1'b1; dread_ea <= ea;
    @(posedge core_clk); dread_req <= 1'b0;
    #1 `CHK({psv_hit, prog_rd}, {hit, hit})
    if (hit) begin
      `CHK({prog_addr, prog_cfg}, {a, 1'b0})
      repeat (3) @(posedge core_clk);
      #1 `CHK({prog_data_valid, prog_data}, {1'b1, 16'(pm(a))})
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, agu_req, agu_write, agu_byte, tbl_req, tbl_high, tbl_byte} = '0;
    {dread_req, pc_load, pc_advance, reg_addr, agu_reg, reg_wdata, agu_ptr} = '0;
    {agu_offset, tbl_ea, dread_ea, pc_load_value} = '0;
    agu_mode = AM_DIRECT;
    sys_rst = 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    // registers: reset values, kept bits, unmapped place
    rd(OFS_MODE, 16'h0f0f);
    wr(OFS_CORE, 16'hffff);
    rd(OFS_CORE, 16'h0004);
    wr(OFS_TABLE_PAGE, 16'hff81);
    pg = 8'h81;
    rd(OFS_TABLE_PAGE, 16'h0081);
    rd(4'hc, 16'h0000);
    $display("registers done");
    // reversed walk over a 16-word buffer on pointer 3, circular also on 3
    agu_reg <= 4'h3;
    wr(OFS_MODE, 16'h8303);
    wr(OFS_BITREV, 16'h8008);
    p = 16'h0100;
    for (int i = 0; i < 16; i++) begin
      s = {revadd(p[15:1], 15'h0008), 1'b0};
      agu(1'b1, 1'b0, AM_POST_INC, p, p, s, 1'b1, 1'b1, 1'b0);
      p = s;
    end
    `CHK(p, 16'h0100)
    // every mode as a word write: only the increment modes reverse
    for (int m = 0; m < 8; m++) begin
      s = {revadd(p[15:1], 15'h0008), 1'b0};
      q = p + 16'h0002;
      brv = (m == 3 || m == 5);
      agu(1'b1, 1'b0, bre_amode_t'(m), p, brv ? ((m == 5) ? s : p) : ((m == 4 || m >= 6) ? q : p),
          brv ? s : q, (m >= 2 && m <= 5), brv, 1'b0);
    end
    agu(1'b1, 1'b1, AM_POST_INC, p, p, p + 16'h0002, 1'b1, 1'b0, 1'b0);
    agu(1'b0, 1'b0, AM_PRE_INC, p, p + 16'h0002, p + 16'h0002, 1'b1, 1'b0, 1'b1);
    wr(OFS_MODE, 16'h8f03);
    agu(1'b1, 1'b0, AM_POST_INC, p, p, p + 16'h0002, 1'b1, 1'b0, 1'b1);
    $display("address generator done");
    // table reads: every kind and byte select, configuration page then user page
    for (int k = 0; k < 8; k++) tbl(k[2], k[1], 16'h4560 | 16'(k[0]));
    wr(OFS_TABLE_PAGE, 16'h0012);
    pg = 8'h12;
    tbl(1'b0, 1'b0, 16'h1234);
    $display("table reads done");
    // window: enable off, lower half, then hits
    wr(OFS_CORE, 16'h0000);
    wr(OFS_VISPAG, 16'h0003);
    vp = 8'h03;
    win(16'h8124, 1'b0);
    wr(OFS_CORE, 16'h0004);
    win(16'h0124, 1'b0);
    win(16'h8124, 1'b1);
    win(16'hfffe, 1'b1);
    rd(OFS_STATUS, 16'h0004);
    $display("window reads done");
    // program counter: load drops bit 0, then three steps of two
    @(posedge core_clk); pc_load <= 1'b1; pc_load_value <= 24'h00_0101;
    @(posedge core_clk); pc_load <= 1'b0; pc_advance <= 1'b1;
    repeat (3) @(posedge core_clk);
    pc_advance <= 1'b0;
    #1 `CHK(pc, 24'h00_0106)
    $display("program counter done");
    wrap_up();
  end
endmodule
